// ---- logic/owr_top.sv ----
// single-wire reader: temperature, seconds counter and identity transactions
`timescale 1ns/1ps
`default_nettype none
module owr_top
  import owr_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int TICK_CYCLES = TICK_DIV
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire owr_op_type op,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  output logic busy,
  output logic done,
  output logic present,
  output logic [63:0] result,
  output logic [7:0] temp_whole
);

  if (CONV_CYCLES < 1 || TICK_CYCLES < 1 || TICK_CYCLES > 32) begin : g_chk
    $error("CONV_CYCLES must be at least 1 and TICK_CYCLES within 1 to 32");
  end

  // ===========================================================================
  // pin synchroniser and 4 MHz tick
  logic dq_m_q, dq_s_q, tick_q, tick_d;
  logic [4:0] div_q, div_d;

  // the tick defines every slot width; a shorter divider only scales time for simulation
  always_comb begin
    tick_d = div_q == 5'(TICK_CYCLES - 1);
    div_d = (div_q == 5'(TICK_CYCLES - 1)) ? 5'h00 : div_q + 5'h01;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dq_m_q <= 1'b1;
      dq_s_q <= 1'b1;
      div_q <= 5'h00;
      tick_q <= 1'b0;
    end else if (ce) begin
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ===========================================================================
  // slot engine
  logic go_q, go_d, rk_q, rk_d, wb_q, wb_d, slot_bit, slot_done;

  owr_slot u_slot (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .tick(tick_q),
    .go(go_q),
    .rkind(rk_q),
    .wbit(wb_q),
    .line(dq_s_q),
    .oe_q(dq_oe),
    .bit_q(slot_bit),
    .done_q(slot_done)
  );

  // ===========================================================================
  // transaction sequencer
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_NEXT = 7'h02, ST_RESET = 7'h04, ST_TX = 7'h08,
    ST_RX = 7'h10, ST_WAIT = 7'h20, ST_END = 7'h40
  } owr_state_type;

  owr_state_type state_q, state_d;
  owr_op_type op_q, op_d;
  owr_step_type cur;
  logic [3:0] step_q, step_d, rxn_q, rxn_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d, whole_q, whole_d;
  logic [31:0] wcnt_q, wcnt_d;
  logic [63:0] res_q, res_d;
  logic fly_q, fly_d, busy_q, busy_d, done_q, done_d, pres_q, pres_d, dq_out_q;

  // one step of the program per pass; each slot is launched once and awaited
  always_comb begin
    cur = owr_prog(op_q, step_q);
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    rxn_d = rxn_q;
    bit_d = bit_q;
    shift_d = shift_q;
    whole_d = whole_q;
    wcnt_d = wcnt_q;
    res_d = res_q;
    fly_d = fly_q;
    busy_d = busy_q;
    pres_d = pres_q;
    go_d = 1'b0;
    rk_d = rk_q;
    wb_d = wb_q;
    done_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        // busy is already low in the done cycle, but a start there is still ignored
        if (start && !done_q) begin
          op_d = op;
          step_d = 4'h0;
          rxn_d = 4'h0;
          res_d = RESULT_RST; // unreceived bytes stay FF
          pres_d = 1'b0;
          busy_d = 1'b1;
          state_d = ST_NEXT;
        end
      end
      ST_NEXT: begin
        bit_d = 3'h0;
        shift_d = cur.data;
        unique case (cur.act)
          ACT_RESET: state_d = ST_RESET;
          ACT_TX: state_d = ST_TX;
          ACT_RX, ACT_SKIP: state_d = ST_RX;
          ACT_WAIT: begin
            wcnt_d = 32'(CONV_CYCLES - 1);
            state_d = ST_WAIT;
          end
          default: state_d = ST_END;
        endcase
      end
      ST_RESET: begin
        if (!fly_q) begin
          go_d = 1'b1;
          rk_d = 1'b1;
          fly_d = 1'b1;
        end else if (slot_done) begin
          fly_d = 1'b0;
          pres_d = slot_bit;
          step_d = step_q + 4'h1;
          // no presence: abandon, leaving every result byte at FF
          state_d = slot_bit ? ST_NEXT : ST_END;
        end
      end
      ST_TX, ST_RX: begin
        if (!fly_q) begin
          go_d = 1'b1;
          rk_d = 1'b0;
          wb_d = (state_q == ST_RX) | shift_q[0]; // read slot is a write-1 slot
          fly_d = 1'b1;
        end else if (slot_done) begin
          fly_d = 1'b0;
          bit_d = bit_q + 3'h1;
          // bytes travel least significant bit first in both directions
          shift_d = (state_q == ST_RX) ? {slot_bit, shift_q[7:1]} : {1'b0, shift_q[7:1]};
          if (bit_q == 3'h7) begin
            step_d = step_q + 4'h1;
            state_d = ST_NEXT;
            if (state_q == ST_RX && cur.act == ACT_RX) begin
              res_d[rxn_q[2:0]*8 +: 8] = shift_d;
              rxn_d = rxn_q + 4'h1;
            end
          end
        end
      end
      ST_WAIT: begin
        if (wcnt_q == 32'h0000_0000) begin
          step_d = step_q + 4'h1;
          state_d = ST_NEXT;
        end else begin
          wcnt_d = wcnt_q - 32'h0000_0001;
        end
      end
      ST_END: begin
        if (op_q == OP_TEMP) whole_d = owr_whole(res_q[15:0]);
        busy_d = 1'b0;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= OP_TEMP;
      step_q <= 4'h0;
      rxn_q <= 4'h0;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      whole_q <= 8'h00;
      wcnt_q <= 32'h0000_0000;
      res_q <= RESULT_RST;
      fly_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pres_q <= 1'b0;
      go_q <= 1'b0;
      rk_q <= 1'b0;
      wb_q <= 1'b0;
      dq_out_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      rxn_q <= rxn_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      whole_q <= whole_d;
      wcnt_q <= wcnt_d;
      res_q <= res_d;
      fly_q <= fly_d;
      busy_q <= busy_d;
      done_q <= done_d;
      pres_q <= pres_d;
      go_q <= go_d;
      rk_q <= rk_d;
      wb_q <= wb_d;
      dq_out_q <= 1'b0; // open drain: only ever drives low
    end
  end

  assign dq_out = dq_out_q;
  assign busy = busy_q;
  assign done = done_q;
  assign present = pres_q;
  assign result = res_q;
  assign temp_whole = whole_q;

  // ===========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !ce);

  AST_CONV_LOAD: assert property (state_q == ST_NEXT && cur.act == ACT_WAIT |=>
    wcnt_q == 32'(CONV_CYCLES - 1)) else $error("conversion wait loaded wrong count");
  AST_CONV_HOLD: assert property (state_q == ST_WAIT && wcnt_q != 32'h0 |=>
    state_q == ST_WAIT) else $error("conversion wait cut short");
  AST_SIGN: assert property (done_q && pres_q && op_q == OP_TEMP |->
    temp_whole[7] == res_q[15]) else $error("whole-degree sign bit wrong");
  AST_MAG_POS: assert property (done_q && pres_q && op_q == OP_TEMP && !res_q[15] |->
    temp_whole[6:0] == res_q[10:4]) else $error("whole-degree size wrong");
  AST_ABSENT_FF: assert property (done_q && !pres_q |-> res_q == RESULT_RST)
    else $error("missing peripheral left non-FF bytes");
  AST_ID_COUNT: assert property (done_q && pres_q && op_q == OP_ID |-> rxn_q == 4'h8)
    else $error("identity read stored wrong byte count");
  AST_CLK_COUNT: assert property (done_q && pres_q && op_q == OP_CLK_RD |->
    rxn_q == 4'h4) else $error("seconds read stored wrong byte count");
  AST_TICK: assert property (tick_q |-> div_q == 5'h00)
    else $error("time base tick out of step with its divider");
  AST_CLR_CTRL: assert property (state_q == ST_TX && op_q == OP_CLK_CLR && step_q == 4'h3
    && bit_q == 3'h0 |-> shift_q == CLK_CTRL_RUN) else $error("clear did not start oscillator");
  AST_DONE_PULSE: assert property (done_q |=> !done_q && !busy_q)
    else $error("done not a single pulse");

  COV_TEMP: cover property (done_q && pres_q && op_q == OP_TEMP);
  COV_CLK: cover property (done_q && pres_q && op_q == OP_CLK_RD);
  COV_ID: cover property (done_q && pres_q && op_q == OP_ID);
  COV_ABSENT: cover property (done_q && !pres_q);

endmodule
`default_nettype wire

// ---- logic/owr_pkg.sv ----
// constants, types and step program for the single-wire sensor and clock reader
//
// Behaviour
// - after a conversion command the reader waits the full 750 ms before reading back.
// - the whole-degree result is one byte in one-degree steps covering -55 to +125 C.
// - the whole-degree byte has bit 7 clear when positive and set when negative (128 + size).
// - the fine read returns the sensor's raw 12-bit value unchanged in a 16-bit word.
// - temperature slot timing is built from a 4 MHz time base.
// - the seconds read stores the 32-bit counter as four bytes, least significant first.
// - the four counter bytes weigh 1, 256, 65536 and 16777216 s (low and high 16-bit word).
// - the counter clear writes a zero count and switches the peripheral oscillator on.
// - the counter clear is the operation to issue after the clock peripheral powers up.
// - clock read and clear slot timing is built from the same 4 MHz time base.
// - the identity read stores family code, six serial bytes, then checksum, in order.
// - bytes not received because the peripheral is gone read as FF; a line shorted low reads as present with 00 bytes.
package owr_pkg;

  // ===========================================================================
  // time base
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 4_000_000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int TK_PER_US = TICK_HZ / 1_000_000;
  localparam int CONV_MS = 750;
  localparam int CONV_CYCLES_DEF = CONV_MS * (CLK_HZ / 1000);

  // ===========================================================================
  // slot timing in microseconds and in 4 MHz ticks
  localparam int RST_LOW_US = 480;
  localparam int RST_SAMPLE_US = 550;
  localparam int RST_TOTAL_US = 960;
  localparam int W1_LOW_US = 6;
  localparam int W0_LOW_US = 60;
  localparam int RD_SAMPLE_US = 15;
  localparam int SLOT_TOTAL_US = 70;
  localparam logic [11:0] RST_LOW_TK = 12'(RST_LOW_US * TK_PER_US);
  localparam logic [11:0] RST_SAMPLE_TK = 12'(RST_SAMPLE_US * TK_PER_US);
  localparam logic [11:0] RST_TOTAL_TK = 12'(RST_TOTAL_US * TK_PER_US);
  localparam logic [11:0] W1_LOW_TK = 12'(W1_LOW_US * TK_PER_US);
  localparam logic [11:0] W0_LOW_TK = 12'(W0_LOW_US * TK_PER_US);
  localparam logic [11:0] RD_SAMPLE_TK = 12'(RD_SAMPLE_US * TK_PER_US);
  localparam logic [11:0] SLOT_TOTAL_TK = 12'(SLOT_TOTAL_US * TK_PER_US);

  // ===========================================================================
  // bus command bytes
  localparam logic [7:0] ROM_SKIP = 8'hCC;
  localparam logic [7:0] ROM_READ = 8'h33;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_READ_PAD = 8'hBE;
  localparam logic [7:0] CMD_READ_CLK = 8'h66;
  localparam logic [7:0] CMD_WRITE_CLK = 8'h99;
  localparam logic [7:0] CLK_CTRL_RUN = 8'h0C;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [63:0] RESULT_RST = 64'hFFFF_FFFF_FFFF_FFFF;

  typedef enum logic [2:0] {
    OP_TEMP = 3'h0, OP_RAW = 3'h1, OP_CLK_RD = 3'h2, OP_CLK_CLR = 3'h3, OP_ID = 3'h4
  } owr_op_type;

  typedef enum logic [2:0] {
    ACT_RESET, ACT_TX, ACT_RX, ACT_SKIP, ACT_WAIT, ACT_END
  } owr_act_type;

  typedef struct packed {
    owr_act_type act;
    logic [7:0] data;
  } owr_step_type;

  // step program of each operation
  function automatic owr_step_type owr_prog(input owr_op_type op, input logic [3:0] idx);
    owr_step_type s;
    s = '{ACT_END, BYTE_ZERO};
    if (idx == 4'h0) begin
      s = '{ACT_RESET, BYTE_ZERO};
    end else begin
      case (op)
        OP_TEMP, OP_RAW: begin
          case (idx)
            4'h1, 4'h5: s = '{ACT_TX, ROM_SKIP};
            4'h2: s = '{ACT_TX, CMD_CONVERT};
            4'h3: s = '{ACT_WAIT, BYTE_ZERO};
            4'h4: s = '{ACT_RESET, BYTE_ZERO};
            4'h6: s = '{ACT_TX, CMD_READ_PAD};
            4'h7, 4'h8: s = '{ACT_RX, BYTE_ZERO};
            default: s = '{ACT_END, BYTE_ZERO};
          endcase
        end
        OP_CLK_RD: begin
          if (idx == 4'h1) s = '{ACT_TX, ROM_SKIP};
          else if (idx == 4'h2) s = '{ACT_TX, CMD_READ_CLK};
          else if (idx == 4'h3) s = '{ACT_SKIP, BYTE_ZERO};
          else if (idx <= 4'h7) s = '{ACT_RX, BYTE_ZERO};
        end
        OP_CLK_CLR: begin
          if (idx == 4'h1) s = '{ACT_TX, ROM_SKIP};
          else if (idx == 4'h2) s = '{ACT_TX, CMD_WRITE_CLK};
          else if (idx == 4'h3) s = '{ACT_TX, CLK_CTRL_RUN};
          else if (idx <= 4'h7) s = '{ACT_TX, BYTE_ZERO};
        end
        OP_ID: begin
          if (idx == 4'h1) s = '{ACT_TX, ROM_READ};
          else if (idx <= 4'h9) s = '{ACT_RX, BYTE_ZERO};
        end
        default: s = '{ACT_END, BYTE_ZERO};
      endcase
    end
    return s;
  endfunction

  // raw 1/16 degree reading to sign and size byte
  function automatic logic [7:0] owr_whole(input logic [15:0] raw);
    logic [15:0] mag;
    mag = raw[15] ? 16'(~raw + 16'h0001) : raw;
    return {raw[15], mag[10:4]};
  endfunction

endpackage

// ---- logic/owr_slot.sv ----
// single slot engine: reset/presence slot or one read/write bit slot
`timescale 1ns/1ps
`default_nettype none
module owr_slot
  import owr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic go,
  input wire logic rkind,
  input wire logic wbit,
  input wire logic line,
  output logic oe_q,
  output logic bit_q,
  output logic done_q
);

  // ===========================================================================
  // slot sequencing
  logic act_q, act_d, oe_d, bit_d, done_d, rk_q, rk_d, wb_q, wb_d;
  logic [11:0] cnt_q, cnt_d, nxt, low_tk, samp_tk, total_tk;

  // timing is counted in 4 MHz ticks so slot widths track the time base
  always_comb begin
    low_tk = rk_q ? RST_LOW_TK : (wb_q ? W1_LOW_TK : W0_LOW_TK);
    samp_tk = rk_q ? RST_SAMPLE_TK : RD_SAMPLE_TK;
    total_tk = rk_q ? RST_TOTAL_TK : SLOT_TOTAL_TK;
    nxt = cnt_q + 12'h001;
    act_d = act_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    bit_d = bit_q;
    rk_d = rk_q;
    wb_d = wb_q;
    done_d = 1'b0;
    if (!act_q && go) begin
      act_d = 1'b1;
      cnt_d = 12'h000;
      oe_d = 1'b1; // every slot opens with the line pulled low
      rk_d = rkind;
      wb_d = wbit;
    end else if (act_q && tick) begin
      cnt_d = nxt;
      oe_d = nxt < low_tk;
      // presence shows as a low line, data as the line itself
      if (nxt == samp_tk) bit_d = rk_q ? !line : line;
      if (nxt == total_tk) begin
        act_d = 1'b0;
        oe_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      act_q <= 1'b0;
      cnt_q <= 12'h000;
      oe_q <= 1'b0;
      bit_q <= 1'b0;
      done_q <= 1'b0;
      rk_q <= 1'b0;
      wb_q <= 1'b0;
    end else if (ce) begin
      act_q <= act_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      bit_q <= bit_d;
      done_q <= done_d;
      rk_q <= rk_d;
      wb_q <= wb_d;
    end
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !ce);

  AST_RESET_HOLD: assert property (!act_q && go && rkind |=> oe_q [*8])
    else $error("reset slot did not hold the line low");
  AST_DONE_IDLE: assert property (done_q |-> !act_q && !oe_q && $past(act_q))
    else $error("slot ended while still driving");

endmodule
`default_nettype wire

// ---- dv/owr_peer_model.sv ----
// behavioural single-wire peripheral: temperature sensor, seconds counter and identity
`timescale 1ns/1ps
`default_nettype none
module owr_peer_model
  import owr_pkg::*;
#(
  parameter logic [31:0] SECS_INIT = 32'h8A5C_3E17,
  parameter longint SEC_NS = 1_000_000_000,
  // one bus microsecond in ns; the bench shrinks it together with the reader tick
  parameter longint US_NS = 1000
) (
  input wire logic line,
  input wire logic attached,
  input wire logic [15:0] temp_raw,
  input wire logic [63:0] rom_id,
  output var logic pull_low,
  output var logic [31:0] secs,
  output var logic osc_on
);
  localparam int M_CMD = 0;
  localparam int M_TX = 1;
  localparam int M_RX = 2;
  logic [63:0] tx;
  logic [39:0] sh;
  logic [7:0] ctrl;
  logic b;
  int mode;
  int n;
  time t0;

  // ==========================================================================
  // power-up: crystal stopped until the first clear
  initial begin
    pull_low = 1'b0;
    secs = SECS_INIT;
    osc_on = 1'b0;
    ctrl = 8'h00;
    mode = 3;
    n = 0;
    tx = '1;
    sh = '0;
  end

  // one count a second, only with the crystal running
  always begin
    #(SEC_NS);
    if (osc_on) secs = secs + 32'h1;
  end

  // ==========================================================================
  // slot decoder: long low is a reset, short low is one bit slot
  always @(negedge line) begin
    if (attached && !pull_low) begin
      t0 = $time;
      if (mode == M_TX && !tx[0]) pull_low = 1'b1; // lsb first
      #(30 * US_NS);
      b = line;
      #(15 * US_NS);
      pull_low = 1'b0;
      if (!line) @(posedge line);
      if ($time - t0 > 300 * US_NS) begin
        // presence answer sits well over the host sample point
        #(30 * US_NS);
        pull_low = 1'b1;
        #(120 * US_NS);
        pull_low = 1'b0;
        mode = M_CMD;
        n = 0;
      end else if (mode == M_TX) begin
        tx = {1'b1, tx[63:1]}; // released line reads as ones
      end else if (mode == M_CMD || mode == M_RX) begin
        sh = {b, sh[39:1]};
        n = n + 1;
        if (mode == M_CMD && n == 8) begin
          n = 0;
          case (sh[39:32])
            ROM_READ: begin
              tx = rom_id; // family, serial, checksum
              mode = M_TX;
            end
            CMD_READ_PAD: begin
              tx = {48'hA5C3_5A3C_96E1, temp_raw};
              mode = M_TX;
            end
            CMD_READ_CLK: begin
              tx = {24'h3C_A55A, secs, ctrl};
              mode = M_TX;
            end
            CMD_WRITE_CLK: mode = M_RX;
            default: mode = M_CMD; // skip and convert: next byte is a command
          endcase
        end else if (mode == M_RX && n == 40) begin
          ctrl = sh[7:0];
          secs = sh[39:8];
          osc_on = (ctrl == CLK_CTRL_RUN);
          mode = 3;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_one_wire_sensor_clock_reader.sv ----
// self-checking bench for the single-wire reader against a behavioural peripheral
`timescale 1ns/1ps
`default_nettype none
module tb_one_wire_sensor_clock_reader
  import owr_pkg::*;
;
  typedef struct packed {
    owr_op_type op;
    logic att;
    logic [15:0] raw;
    logic pres;
    logic [63:0] res;
    logic [7:0] whole;
  } owr_row_type;
  localparam logic [63:0] ROM_ID = 64'h5B3D_A1C4_7E29_0613; // arbitrary value
  localparam logic [31:0] SECS0 = 32'h8A5C_3E17;
  localparam logic [47:0] ONES48 = '1;
  localparam logic [63:0] ONES = '1;
  logic clock, rst, ce, start, dq_out, dq_oe, busy, done, present;
  logic attached, pull_low, osc_on, line;
  owr_op_type op;
  logic [63:0] result;
  logic [7:0] temp_whole;
  logic [15:0] temp_raw;
  logic [31:0] secs;
  int fail_count = 0;
  int checks_done = 0;
  owr_row_type rows [0:8] = '{
    '{OP_CLK_RD, 1'b1, 16'h0000, 1'b1, {32'hFFFF_FFFF, SECS0}, 8'h00},
    '{OP_CLK_CLR, 1'b1, 16'h0000, 1'b1, ONES, 8'h00},
    '{OP_CLK_RD, 1'b1, 16'h0000, 1'b1, {32'hFFFF_FFFF, 32'h0}, 8'h00},
    '{OP_RAW, 1'b1, 16'hFF5E, 1'b1, {ONES48, 16'hFF5E}, 8'h00},
    '{OP_TEMP, 1'b1, 16'h07D0, 1'b1, {ONES48, 16'h07D0}, 8'h7D},
    '{OP_TEMP, 1'b1, 16'hFC90, 1'b1, {ONES48, 16'hFC90}, 8'hB7},
    '{OP_ID, 1'b1, 16'h0000, 1'b1, ROM_ID, 8'h00},
    '{owr_op_type'(3'h5), 1'b1, 16'h0000, 1'b1, ONES, 8'h00},
    '{OP_TEMP, 1'b0, 16'h0000, 1'b0, ONES, 8'h80}
  };

  // ==========================================================================
  // open-drain wire with pull-up, shared by reader and peripheral
  assign line = ~(dq_oe | (pull_low & attached));

  // one tick per clock: a bus microsecond becomes four clocks, 40 ns
  owr_top #(
    .CONV_CYCLES(50), .TICK_CYCLES(1)
  ) u_owr_top (
    .clock(clock), .rst(rst), .ce(ce), .start(start), .op(op), .dq_in(line),
    .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy), .done(done), .present(present),
    .result(result), .temp_whole(temp_whole)
  );

  owr_peer_model #(
    .US_NS(40)
  ) u_owr_peer_model (
    .line(line), .attached(attached), .temp_raw(temp_raw), .rom_id(ROM_ID),
    .pull_low(pull_low), .secs(secs), .osc_on(osc_on)
  );

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic kick(input owr_op_type o);
    @(posedge clock);
    #1 start = 1'b1;
    op = o;
    @(posedge clock);
    #1 start = 1'b0;
    check("busy after start", 64'h1, {63'h0, busy});
  endtask

  // bounded wait: the longest transaction needs about 24k cycles
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 40_000) begin
      @(posedge clock);
      #1 n++;
    end
    check("done", 64'h2, {62'h0, done, busy});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: all cases together need about 1.9 ms at the scaled time base
  initial begin
    #3_000_000;
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    op = OP_TEMP;
    temp_raw = 16'h0000;
    attached = 1'b1;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    check("idle after reset", 64'h0, {60'h0, dq_oe, dq_out, busy, present});
    check("result after reset", ONES, result);
    // table of ordinary transactions
    for (int i = 0; i <= 8; i++) begin
      attached = rows[i].att;
      temp_raw = rows[i].raw;
      kick(rows[i].op);
      wait_done();
      check("present", {63'h0, rows[i].pres}, {63'h0, present});
      check("result", rows[i].res, result);
      if (rows[i].op == OP_TEMP) begin
        check("temp_whole", {56'h0, rows[i].whole}, {56'h0, temp_whole});
      end
      if (i == 1) begin
        check("crystal on", 64'h1, {63'h0, osc_on});
      end
    end
    // reset in the middle of a transaction
    attached = 1'b1;
    kick(OP_ID);
    repeat (6000) @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check("reset mid-run", 64'h0, {53'h0, dq_oe, busy, present, temp_whole});
    check("result mid-run reset", ONES, result);
    // peripheral pulled off once three bytes are in; a start meanwhile is ignored
    kick(OP_ID);
    while (result[23:16] !== ROM_ID[23:16]) begin
      @(posedge clock);
      #1;
    end
    attached = 1'b0;
    start = 1'b1;
    op = OP_CLK_CLR;
    @(posedge clock);
    #1 start = 1'b0;
    wait_done();
    check("removed present", 64'h1, {63'h0, present});
    check("removed result", {40'hFF_FFFF_FFFF, ROM_ID[23:0]}, result);
    end_of_test();
  end
endmodule
`default_nettype wire
